// ===== rtl/tsrb_pkg.sv
// shared constants and types of the temperature sensor register bank
package tsrb_pkg;
  localparam int          PTR_W          = 8;
  localparam int          REG_W          = 16;
  localparam int          RES_W          = 13;
  localparam int          NUM_CH         = 9;
  localparam int          RES_LSB        = 3;
  localparam int          SWRST_BIT      = 15;
  localparam int          STAT_LOCAL_BIT = 7;
  localparam int          BITS_PER_BYTE  = 8;
  localparam logic [7:0]  PTR_RESET      = 8'h00;
  localparam logic [7:0]  PTR_LOCAL      = 8'h00;
  localparam logic [7:0]  PTR_REMOTE8    = 8'h08;
  localparam logic [7:0]  PTR_SWRST      = 8'h20;
  localparam logic [7:0]  PTR_STATUS     = 8'h21;
  localparam logic [7:0]  PTR_LOCK       = 8'hC4;
  localparam logic [7:0]  PTR_MAKER      = 8'hFE;
  localparam logic [7:0]  PTR_PART       = 8'hFF;
  localparam logic [15:0] LOCK_CODE      = 16'h5CA6;
  localparam logic [15:0] UNLOCK_CODE    = 16'hEB19;
  localparam logic [15:0] LOCK_RD_SET    = 16'h8000;
  localparam logic [15:0] LOCK_RD_CLEAR  = 16'h0000;
  localparam logic        LOCK_RESET     = 1'h1;
  localparam logic [15:0] ZERO_WORD      = 16'h0000;
  localparam logic [12:0] RES_RESET      = 13'h0000;
  localparam logic [3:0]  CNT_ZERO       = 4'h0;
  localparam logic [3:0]  CNT_ONE        = 4'h1;
  localparam logic [3:0]  CNT_BYTE       = 4'h8;
  localparam logic [1:0]  IDX_PTR        = 2'h0;
  localparam logic [1:0]  IDX_MSB        = 2'h1;
  localparam logic [1:0]  IDX_LSB        = 2'h2;
  localparam logic [1:0]  IDX_EXTRA      = 2'h3;

  // two-wire slave states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WR_BYTE  = 7'h08,
    ST_WR_ACK   = 7'h10,
    ST_RD_BYTE  = 7'h20,
    ST_RD_ACK   = 7'h40
  } tsrb_state_t;
endpackage : tsrb_pkg

// ===== rtl/tsrb_sync.sv
// two-flop synchroniser for pin inputs that idle high
`timescale 1ns/1ns
module tsrb_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  if (WIDTH < 1) begin : g_chk
    $error("tsrb_sync: WIDTH must be at least 1");
  end

  // reset to idle-high so no false start appears after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{1'h1}};
      sync_q <= {WIDTH{1'h1}};
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule : tsrb_sync

// ===== rtl/tsrb_chan.sv
// one channel: result register and over-limit flag with hysteresis
`timescale 1ns/1ns
module tsrb_chan #(
  parameter int RES_W = 13
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clr,
  input  wire logic             load,
  input  wire logic [RES_W-1:0] din,
  input  wire logic [RES_W-1:0] limit,
  input  wire logic [RES_W-1:0] hyst,
  output logic      [RES_W-1:0] result_q,
  output logic                  flag_q
);
  logic signed [RES_W+1:0] res_x;
  logic signed [RES_W+1:0] thr_x;

  if (RES_W < 2) begin : g_chk
    $error("tsrb_chan: RES_W too small");
  end

  // two extra bits: lowest limit minus largest hysteresis must not wrap
  assign res_x = $signed({{2{din[RES_W-1]}}, din});
  assign thr_x = $signed({{2{limit[RES_W-1]}}, limit}) - $signed({2'h0, hyst});

  // result is replaced whole on every completed conversion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= '0;
    end else if (clr) begin
      result_q <= '0;
    end else if (load) begin
      result_q <= din;
    end
  end

  // set above limit, self-clears at or below limit minus hysteresis
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'h0;
    end else if (clr) begin
      flag_q <= 1'h0;
    end else if (load) begin
      if (res_x > $signed({limit[RES_W-1], limit})) begin
        flag_q <= 1'h1;
      end else if (res_x <= thr_x) begin
        flag_q <= 1'h0;
      end
    end
  end
endmodule : tsrb_chan

// ===== rtl/tsrb_top.sv
// two-wire slave and register bank of the multichannel temperature monitor
`timescale 1ns/1ns
module tsrb_top #(
  parameter logic [6:0]  DEV_ADDR = 7'h48,
  parameter logic [15:0] MAKER_ID = 16'h00A5, // arbitrary value
  parameter logic [15:0] PART_ID  = 16'h0101  // arbitrary value
) (
  input  wire logic         MCLK,
  input  wire logic         RESETN,
  input  wire logic         SCL_IN,
  input  wire logic         SDA_IN,
  input  wire logic         CONV_DONE,
  input  wire logic [3:0]   CONV_CHANNEL,
  input  wire logic [12:0]  CONV_RESULT,
  input  wire logic [116:0] LIMITS,
  input  wire logic [12:0]  HYSTERESIS,
  output logic              SDA_OUT,
  output logic              SDA_OE,
  output logic              LOCKED,
  output logic              SOFT_RESET
);
  localparam int NCH = tsrb_pkg::NUM_CH;
  localparam int RW  = tsrb_pkg::RES_W;

  if (NCH * RW != 117 || DEV_ADDR == 7'h00) begin : g_chk
    $error("tsrb_top: channel layout or device address not supported");
  end

  logic [1:0]            rst_pipe_q, bus_s, bus_p_q, idx_q;
  logic                  rst_n, scl_rise, scl_fall, start_ev, stop_ev;
  tsrb_pkg::tsrb_state_t state_q, state_d;
  logic [3:0]            cnt_q;
  logic [7:0]            shift_q, tx_q, tx_load, ptr_q, wr_msb_q;
  logic                  rw_q, msb_sent_q, locked_q, soft_q, sda_oe_q;
  logic [15:0]           wr_word, rd_mux, rd_word_q;
  logic                  addr_done, addr_match, byte_done, commit, swrst_req;
  logic                  rd_start, rd_next, rd_shift, rd_end;
  logic [RW-1:0]         res_arr [NCH];
  logic [NCH-1:0]        flags;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'h1};
    end
  end
  assign rst_n = rst_pipe_q[1];

  // pins are asynchronous to MCLK
  tsrb_sync #(.WIDTH (2)) u_sync (
    .clk   (MCLK),
    .rst_n (rst_n),
    .din   ({SCL_IN, SDA_IN}),
    .dout  (bus_s)
  );

  // previous synchronised level for edge and condition detection
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      bus_p_q <= 2'h3;
    end else begin
      bus_p_q <= bus_s;
    end
  end

  assign scl_rise = bus_s[1] & ~bus_p_q[1];
  assign scl_fall = ~bus_s[1] & bus_p_q[1];
  assign start_ev = bus_s[1] & bus_p_q[1] & bus_p_q[0] & ~bus_s[0];
  assign stop_ev  = bus_s[1] & bus_p_q[1] & ~bus_p_q[0] & bus_s[0];

  // protocol events
  assign addr_done  = (state_q == tsrb_pkg::ST_ADDR) & scl_fall & (cnt_q == tsrb_pkg::CNT_BYTE);
  assign addr_match = (shift_q[7:1] == DEV_ADDR);
  assign byte_done  = (state_q == tsrb_pkg::ST_WR_BYTE) & scl_fall
                    & (cnt_q == tsrb_pkg::CNT_BYTE);
  assign commit     = byte_done & (idx_q == tsrb_pkg::IDX_LSB);
  assign rd_start   = (state_q == tsrb_pkg::ST_ADDR_ACK) & scl_fall & rw_q;
  assign rd_next    = (state_q == tsrb_pkg::ST_RD_ACK) & scl_fall;
  assign rd_shift   = (state_q == tsrb_pkg::ST_RD_BYTE) & scl_fall
                    & (cnt_q != tsrb_pkg::CNT_BYTE);
  assign rd_end     = (state_q == tsrb_pkg::ST_RD_BYTE) & scl_fall
                    & (cnt_q == tsrb_pkg::CNT_BYTE);
  assign wr_word    = {wr_msb_q, shift_q};

  // next state; start and stop override any bit in flight
  always_comb begin
    state_d = state_q;
    case (state_q)
      tsrb_pkg::ST_IDLE:     state_d = tsrb_pkg::ST_IDLE;
      tsrb_pkg::ST_ADDR:
        if (addr_done) state_d = addr_match ? tsrb_pkg::ST_ADDR_ACK : tsrb_pkg::ST_IDLE;
      tsrb_pkg::ST_ADDR_ACK:
        if (scl_fall) state_d = rw_q ? tsrb_pkg::ST_RD_BYTE : tsrb_pkg::ST_WR_BYTE;
      tsrb_pkg::ST_WR_BYTE:  if (byte_done) state_d = tsrb_pkg::ST_WR_ACK;
      tsrb_pkg::ST_WR_ACK:   if (scl_fall) state_d = tsrb_pkg::ST_WR_BYTE;
      tsrb_pkg::ST_RD_BYTE:  if (rd_end) state_d = tsrb_pkg::ST_RD_ACK;
      tsrb_pkg::ST_RD_ACK: begin
        // host nack ends the read; wait for stop or a new start
        if (scl_rise && bus_s[0]) begin
          state_d = tsrb_pkg::ST_IDLE;
        end else if (scl_fall) begin
          state_d = tsrb_pkg::ST_RD_BYTE;
        end
      end
      default:               state_d = tsrb_pkg::ST_IDLE;
    endcase
    if (stop_ev) begin
      state_d = tsrb_pkg::ST_IDLE;
    end else if (start_ev) begin
      state_d = tsrb_pkg::ST_ADDR;
    end
  end
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= tsrb_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // bit counter: rising edges when receiving, falling edges when sending
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= tsrb_pkg::CNT_ZERO;
    end else if (start_ev || (scl_fall && (state_q == tsrb_pkg::ST_ADDR_ACK
                              || state_q == tsrb_pkg::ST_WR_ACK))) begin
      cnt_q <= rd_start ? tsrb_pkg::CNT_ONE : tsrb_pkg::CNT_ZERO;
    end else if (rd_next) begin
      cnt_q <= tsrb_pkg::CNT_ONE;
    end else if (rd_shift || (scl_rise && (state_q == tsrb_pkg::ST_ADDR
                                     || state_q == tsrb_pkg::ST_WR_BYTE))) begin
      cnt_q <= cnt_q + tsrb_pkg::CNT_ONE;
    end
  end

  // receive shifter, msb first
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 8'h00;
    end else if (scl_rise && (state_q == tsrb_pkg::ST_ADDR
                              || state_q == tsrb_pkg::ST_WR_BYTE)) begin
      shift_q <= {shift_q[6:0], bus_s[0]};
    end
  end

  // direction bit of the address byte
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      rw_q <= 1'h0;
    end else if (addr_done) begin
      rw_q <= shift_q[0];
    end
  end

  // register read mux; unassigned pointers return zero
  always_comb begin
    rd_mux = tsrb_pkg::ZERO_WORD;
    if (ptr_q <= tsrb_pkg::PTR_REMOTE8) begin
      rd_mux = {res_arr[ptr_q[3:0]], 3'h0};
    end else if (ptr_q == tsrb_pkg::PTR_STATUS) begin
      rd_mux = {flags, 7'h00}; // no write path exists
    end else if (ptr_q == tsrb_pkg::PTR_LOCK) begin
      rd_mux = locked_q ? tsrb_pkg::LOCK_RD_SET : tsrb_pkg::LOCK_RD_CLEAR;
    end else if (ptr_q == tsrb_pkg::PTR_MAKER) begin
      rd_mux = MAKER_ID;
    end else if (ptr_q == tsrb_pkg::PTR_PART) begin
      rd_mux = PART_ID;
    end
  end

  // whole word captured at read start so both bytes are coherent
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      rd_word_q <= tsrb_pkg::ZERO_WORD;
    end else if (rd_start) begin
      rd_word_q <= rd_mux;
    end
  end

  // msb byte first, then lsb; longer reads keep alternating
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      msb_sent_q <= 1'h0;
    end else if (rd_start) begin
      msb_sent_q <= 1'h1;
    end else if (rd_next) begin
      msb_sent_q <= ~msb_sent_q;
    end
  end
  assign tx_load = rd_start ? rd_mux[15:8]
                 : (msb_sent_q ? rd_word_q[7:0] : rd_word_q[15:8]);

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= 8'h00;
    end else if (rd_start || rd_next) begin
      tx_q <= tx_load;
    end else if (rd_shift) begin
      tx_q <= {tx_q[6:0], 1'h0};
    end
  end

  // open-drain drive: enable means pull low; changes after scl falls, and clears on start or stop while scl is high
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_q <= 1'h0;
    end else if (start_ev || stop_ev) begin
      sda_oe_q <= 1'h0;
    end else if (addr_done) begin
      sda_oe_q <= addr_match;
    end else if (byte_done) begin
      sda_oe_q <= 1'h1; // every data byte acked
    end else if (rd_start || rd_next) begin
      sda_oe_q <= ~tx_load[7];
    end else if (rd_shift) begin
      sda_oe_q <= ~tx_q[6];
    end else if (rd_end || (scl_fall && (state_q == tsrb_pkg::ST_ADDR_ACK
                                   || state_q == tsrb_pkg::ST_WR_ACK))) begin
      sda_oe_q <= 1'h0;
    end
  end

  // data byte index within a write transaction
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= tsrb_pkg::IDX_PTR;
    end else if (addr_done) begin
      idx_q <= tsrb_pkg::IDX_PTR;
    end else if (byte_done && idx_q != tsrb_pkg::IDX_EXTRA) begin
      idx_q <= idx_q + tsrb_pkg::IDX_MSB;
    end
  end

  // pointer loaded by the first byte of each write
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= tsrb_pkg::PTR_RESET;
    end else if (soft_q) begin
      ptr_q <= tsrb_pkg::PTR_RESET;
    end else if (byte_done && idx_q == tsrb_pkg::IDX_PTR) begin
      ptr_q <= shift_q;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_msb_q <= 8'h00;
    end else if (byte_done && idx_q == tsrb_pkg::IDX_MSB) begin
      wr_msb_q <= shift_q;
    end
  end

  // soft reset only from an unlocked device; pointers other than the soft reset and lock pointers drop data
  assign swrst_req = commit & (ptr_q == tsrb_pkg::PTR_SWRST)
                   & wr_word[tsrb_pkg::SWRST_BIT] & ~locked_q;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      soft_q <= 1'h0;
    end else begin
      soft_q <= swrst_req;
    end
  end

  // lock state; soft reset restores the power-on locked value
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      locked_q <= tsrb_pkg::LOCK_RESET;
    end else if (soft_q) begin
      locked_q <= tsrb_pkg::LOCK_RESET;
    end else if (commit && ptr_q == tsrb_pkg::PTR_LOCK) begin
      if (wr_word == tsrb_pkg::LOCK_CODE) begin
        locked_q <= 1'h1;
      end else if (wr_word == tsrb_pkg::UNLOCK_CODE) begin
        locked_q <= 1'h0;
      end
    end
  end

  // per-channel result and flag; channel 0 local, 1..8 remote
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    tsrb_chan #(.RES_W (RW)) u_chan (
      .clk      (MCLK),
      .rst_n    (rst_n),
      .clr      (soft_q),
      .load     (CONV_DONE && CONV_CHANNEL == 4'(i)),
      .din      (CONV_RESULT),
      .limit    (LIMITS[i*RW +: RW]),
      .hyst     (HYSTERESIS),
      .result_q (res_arr[i]), // zero until first conversion
      .flag_q   (flags[i])
    );
  end

  // outputs straight from flops, except SDA_OUT which is tied low
  assign SDA_OUT    = 1'h0;
  assign SDA_OE     = sda_oe_q;
  assign LOCKED     = locked_q;
  assign SOFT_RESET = soft_q;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!rst_n);

  a_ptr_load: assert property (byte_done && idx_q == tsrb_pkg::IDX_PTR |=>
    ptr_q == $past(shift_q)) else $error("pointer not loaded by first byte");
  a_ptr_por: assert property ($rose(rst_n) |-> ptr_q == tsrb_pkg::PTR_RESET)
    else $error("pointer not zero after reset");
  a_discard_wr: assert property (commit && ptr_q != tsrb_pkg::PTR_SWRST
    && ptr_q != tsrb_pkg::PTR_LOCK |=> $stable(locked_q) && !soft_q)
    else $error("write to other pointer had an effect");
  a_addr_ack: assert property (addr_done && addr_match |=> SDA_OE [*1]
    ##0 state_q == tsrb_pkg::ST_ADDR_ACK) else $error("address not acked");
  a_result_load: assert property (CONV_DONE && CONV_CHANNEL < 4'h9 && !soft_q
    |=> res_arr[$past(CONV_CHANNEL)] == $past(CONV_RESULT))
    else $error("result not updated on conversion");
  a_res_zero: assert property ($rose(rst_n) |-> res_arr[0] == 13'h0000
    && res_arr[8] == 13'h0000) else $error("result not zero after reset");
  a_msb_first: assert property (rd_start |=> SDA_OE == ~$past(rd_mux[15]))
    else $error("read did not start with msb");
  a_swrst_fire: assert property (swrst_req |=> soft_q ##1
    ptr_q == tsrb_pkg::PTR_RESET && res_arr[0] == 13'h0000)
    else $error("soft reset did not clear registers");
  a_swrst_lock: assert property (commit && locked_q |=> !soft_q)
    else $error("soft reset while locked");
  a_lock_code: assert property (commit && ptr_q == tsrb_pkg::PTR_LOCK
    && wr_word == tsrb_pkg::UNLOCK_CODE |=> !LOCKED) else $error("unlock failed");
  a_lock_read: assert property (rd_start && ptr_q == tsrb_pkg::PTR_LOCK
    |=> rd_word_q[15] == $past(locked_q) && rd_word_q[14:0] == 15'h0000)
    else $error("lock readback wrong");
  a_status_fmt: assert property (rd_start && ptr_q == tsrb_pkg::PTR_STATUS
    |=> rd_word_q[15:7] == $past(flags) && rd_word_q[6:0] == 7'h00)
    else $error("status layout wrong");
  a_flag_set: assert property (CONV_DONE && CONV_CHANNEL == 4'h0 && !soft_q
    && $signed(CONV_RESULT) > $signed(LIMITS[12:0]) |=> flags[0])
    else $error("local flag not set above limit");

  c_read: cover property (rd_next ##[1:200] rd_end);
  c_lock: cover property (locked_q ##1 !locked_q);
  c_swrst: cover property (soft_q);
endmodule : tsrb_top

// ===== verification/tsrb_host.sv
// two-wire bus host model that drives the register bank's pins
`timescale 1ns/1ns
module tsrb_host #(
  parameter logic [6:0] DEV_ADDR = 7'h48
) (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda
);
  // bus idles released; the clock stands high outside frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // one bit: data moves mid-low, sampled late in the high phase, clear of device turnaround
  task automatic bit_x(input logic b, output logic r);
    scl <= 1'b0;
    repeat (2) @(posedge clk);
    sda <= b;
    repeat (2) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    r = sda_line;
  endtask : bit_x

  // one byte plus the ninth acknowledge bit
  task automatic byte_x(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                        output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], r); // msb first
      rx[i] = r;
    end
    bit_x(ack_in, r);
    ack = ~r;
  endtask : byte_x

  // start: data falls while the clock is high
  task automatic start_x();
    @(posedge clk);
    sda <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : start_x

  // stop: data rises while the clock is high
  task automatic stop_x();
    logic r;
    bit_x(1'b0, r);
    sda <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : stop_x

  // write: pointer byte, then n data bytes of the word
  task automatic wr(input logic [7:0] ptr, input int n, input logic [15:0] w, output logic ok);
    logic [7:0] rx;
    logic       a;
    start_x();
    byte_x({DEV_ADDR, 1'b0}, 1'b1, rx, ok);
    byte_x(ptr, 1'b1, rx, a); // first byte is the pointer
    ok = ok & a;
    if (n > 0) begin
      byte_x(w[15:8], 1'b1, rx, a);
      ok = ok & a;
    end
    if (n > 1) begin
      byte_x(w[7:0], 1'b1, rx, a);
      ok = ok & a;
    end
    stop_x();
  endtask : wr

  // read one word, optionally setting the pointer first
  task automatic rd(input logic set, input logic [7:0] ptr, output logic [15:0] w,
                    output logic ok);
    logic [7:0] rx;
    logic       a;
    ok = 1'b1;
    if (set) begin
      wr(ptr, 0, 16'h0000, ok); // pointer set before the read
    end
    start_x();
    byte_x({DEV_ADDR, 1'b1}, 1'b1, rx, a);
    ok = ok & a;
    byte_x(8'hFF, 1'b0, w[15:8], a); // msb then lsb
    byte_x(8'hFF, 1'b1, w[7:0], a);
    stop_x();
  endtask : rd
endmodule : tsrb_host

// ===== verification/tb_tsrb_top.sv
// self-checking bench of the register bank through its two-wire port
`timescale 1ns/1ns
module tb_tsrb_top;
  logic         mclk;
  logic         resetn;
  logic         scl;
  logic         sda_h;
  logic         conv_done;
  logic [3:0]   conv_ch;
  logic [12:0]  conv_res;
  logic [116:0] limits;
  logic [12:0]  hyst;
  logic         sda_out;
  logic         sda_oe;
  logic         locked;
  logic         soft_rst;
  wire          sda_line;
  logic [15:0]  w;
  logic         ok;
  int           mismatches;
  int           cmp_count;
  int           srst_cnt;

  // open-drain data line with pull-up
  assign sda_line = sda_h & ~sda_oe;

  tsrb_top dut (
    .MCLK(mclk), .RESETN(resetn), .SCL_IN(scl), .SDA_IN(sda_line),
    .CONV_DONE(conv_done), .CONV_CHANNEL(conv_ch), .CONV_RESULT(conv_res),
    .LIMITS(limits), .HYSTERESIS(hyst), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .LOCKED(locked), .SOFT_RESET(soft_rst)
  );

  tsrb_host host (.clk(mclk), .sda_line(sda_line), .scl(scl), .sda(sda_h));

  // 20 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // count soft reset pulses; a one-cycle pulse is seen only at its own edge
  always @(posedge mclk) begin
    if (soft_rst === 1'b1) srst_cnt++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] ptr, input logic [15:0] exp);
    host.rd(1'b1, ptr, w, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(w, exp);
  endtask : rd_chk

  task automatic wr_chk(input logic [7:0] ptr, input logic [15:0] d);
    host.wr(ptr, 2, d, ok);
    chk({15'h0000, ok}, 16'h0001);
  endtask : wr_chk

  // one conversion-complete pulse
  task automatic conv(input logic [3:0] ch, input logic [12:0] v);
    @(posedge mclk);
    conv_done <= 1'b1;
    conv_ch   <= ch;
    conv_res  <= v;
    @(posedge mclk);
    conv_done <= 1'b0;
  endtask : conv

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // hang guard
  initial begin
    repeat (50000) @(posedge mclk);
    mismatches++;
    $display("FAIL %0t run did not end", $time);
    test_done();
  end

  // main sequence; limits trip local at 50h and remote 8 at 100h only
  initial begin
    resetn = 1'b0;
    conv_done = 1'b0;
    conv_ch = 4'h0;
    conv_res = 13'h0000;
    hyst = 13'h0010;
    limits = {13'h0100, {7{13'h0FFF}}, 13'h0050};
    mismatches = 0;
    cmp_count = 0;
    srst_cnt = 0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (6) @(posedge mclk);
    host.rd(1'b0, 8'h00, w, ok);
    chk(w, 16'h0000);
    chk({15'h0000, locked}, 16'h0001);
    chk({15'h0000, sda_out}, 16'h0000);
    rd_chk(8'hC4, 16'h8000);
    for (int ch = 0; ch < 9; ch++) begin
      conv(ch[3:0], 13'h00A1 + 13'(ch));
      rd_chk(ch[7:0], {13'h00A1 + 13'(ch), 3'h0});
    end
    conv(4'h8, 13'h0200);
    rd_chk(8'h21, 16'h8080);
    wr_chk(8'h21, 16'hFFFF);
    rd_chk(8'h21, 16'h8080);
    conv(4'h8, 13'h00F8);
    rd_chk(8'h21, 16'h8080);
    conv(4'h8, 13'h00F0);
    rd_chk(8'h21, 16'h0080);
    wr_chk(8'h08, 16'h1234);
    rd_chk(8'h08, 16'h0780);
    wr_chk(8'h10, 16'hFFFF);
    host.rd(1'b1, 8'h10, w, ok);
    chk({15'h0000, ok}, 16'h0001);
    rd_chk(8'h00, 16'h0508);
    wr_chk(8'h20, 16'h8000);
    repeat (4) @(posedge mclk);
    chk(16'(srst_cnt), 16'h0000);
    rd_chk(8'h00, 16'h0508);
    wr_chk(8'hC4, 16'h1234);
    chk({15'h0000, locked}, 16'h0001);
    wr_chk(8'hC4, 16'hEB19);
    chk({15'h0000, locked}, 16'h0000);
    rd_chk(8'hC4, 16'h0000);
    wr_chk(8'hC4, 16'h5CA6);
    chk({15'h0000, locked}, 16'h0001);
    wr_chk(8'hC4, 16'hEB19);
    wr_chk(8'h20, 16'h7FFF);
    repeat (4) @(posedge mclk);
    chk(16'(srst_cnt), 16'h0000);
    rd_chk(8'h20, 16'h0000);
    wr_chk(8'h20, 16'h8000);
    repeat (4) @(posedge mclk);
    chk(16'(srst_cnt), 16'h0001);
    chk({15'h0000, locked}, 16'h0001);
    host.rd(1'b0, 8'h00, w, ok);
    chk(w, 16'h0000);
    test_done();
  end
endmodule : tb_tsrb_top
